// ===== npe_pkg.sv
// Purpose: Shared constants and types for the NOR command sequencer.
// Assumes: 25 MHz core clock; serial pins are asynchronous to it.
// Notes:   Self-timed durations are plain defaults; the top module overrides them.
package npe_pkg;

  localparam logic [7:0]  OP_SEC_READ       = 8'h48;
  localparam logic [7:0]  OP_SEC_ERASE      = 8'h44;
  localparam logic [7:0]  OP_SEC_PROG       = 8'h42;
  localparam logic [7:0]  OP_PAGE_PROG      = 8'h02;
  localparam logic [7:0]  OP_SECTOR_ERASE   = 8'h20;
  localparam logic [7:0]  OP_BLK32_ERASE    = 8'h52;
  localparam logic [7:0]  OP_BLK64_ERASE    = 8'hd8;

  localparam logic [7:0]  ERASED_BYTE       = 8'hff;
  localparam logic [9:0]  SEC_RD_LAST       = 10'h3ff;
  localparam logic [9:0]  SEC_RD_FIRST      = 10'h000;
  localparam int          SEC_SEL_LSB       = 12;
  localparam logic [9:0]  HDR_OPCODE_BYTES  = 10'h001;
  localparam logic [9:0]  HDR_CMD_BYTES     = 10'h004;
  localparam logic [9:0]  HDR_READ_BYTES    = 10'h005;
  localparam logic [9:0]  BYTE_COUNT_MAX    = 10'h3ff;

  localparam logic [10:0] WALK_PAGE_LEN     = 11'h100;
  localparam logic [10:0] WALK_SEC_LEN      = 11'h400;

  localparam logic [24:0] ARRAY_BYTES       = 25'h0080000;
  localparam logic [24:0] SECTOR_BYTES      = 25'h0001000;
  localparam logic [24:0] SMALL_MAX_BYTES   = 25'h0008000;
  localparam logic [24:0] BLK64_BYTES       = 25'h0010000;
  localparam logic [23:0] PAGE_MASK         = 24'h0000ff;
  localparam logic [23:0] SECTOR_MASK       = 24'h000fff;
  localparam logic [23:0] BLK32_MASK        = 24'h007fff;
  localparam logic [23:0] BLK64_MASK        = 24'h00ffff;

  localparam int          CLK_MHZ           = 25;
  localparam int          PAGE_PROGRAM_TIME_US = 1000;
  localparam int          SECTOR_ERASE_TIME_US = 2000;
  localparam int          BLOCK_ERASE_TIME_US  = 4000;
  localparam int          PAGE_PROGRAM_CYCLES  = PAGE_PROGRAM_TIME_US * CLK_MHZ;
  localparam int          SECTOR_ERASE_CYCLES  = SECTOR_ERASE_TIME_US * CLK_MHZ;
  localparam int          BLOCK_ERASE_CYCLES   = BLOCK_ERASE_TIME_US * CLK_MHZ;

  typedef enum logic [1:0] {
    NPE_IDLE  = 2'b00,
    NPE_WALK  = 2'b01,
    NPE_WAIT  = 2'b10
  } npe_state_t;

  typedef enum logic [1:0] {
    NPE_JOB_PAGE      = 2'b00,
    NPE_JOB_SEC_PROG  = 2'b01,
    NPE_JOB_SEC_ERASE = 2'b10,
    NPE_JOB_ARR_ERASE = 2'b11
  } npe_job_t;

endpackage

// ===== npe_mem.sv
// Purpose: Single-port byte memory with registered read data.
// Assumes: Read and write share one address; content is undefined at power-up.
// Notes:   Used for the security register store and for the page buffer.
`timescale 1ns/1ps
module npe_mem #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 256,
  parameter int AW    = 8
) (
  input  wire logic             clock,
  input  wire logic             we,
  input  wire logic [AW-1:0]    addr,
  input  wire logic [WIDTH-1:0] wdata,
  output logic      [WIDTH-1:0] rdata
);

  logic [WIDTH-1:0] mem [DEPTH];

  always_ff @(posedge clock)
  begin
    if (we)
    begin
      mem[addr] <= wdata;
    end
    rdata <= mem[addr];
  end

endmodule

// ===== npe_sequencer.sv
// Purpose: Serial command decoder and self-timed sequencer for program and erase.
// Assumes: Status bits come from an outside status register; main array is outside.
// Notes:   Serial pins pass two flops before use, so edges are seen a few cycles late.
`timescale 1ns/1ps
module npe_sequencer
  import npe_pkg::*;
#(
  parameter int PROG_CYCLES      = PAGE_PROGRAM_CYCLES,
  parameter int SEC_ERASE_CYCLES = SECTOR_ERASE_CYCLES,
  parameter int BLK_ERASE_CYCLES = BLOCK_ERASE_CYCLES
) (
  input  wire logic        clock,
  input  wire logic        reset,
  input  wire logic        cs_n,
  input  wire logic        sclk,
  input  wire logic        si,
  output logic             so_ff,
  output logic             so_oe_ff,
  input  wire logic        write_enable_latch,
  input  wire logic [2:0]  per_register_otp_locks,
  input  wire logic        small_unit_protect_select,
  input  wire logic        top_bottom_protect_select,
  input  wire logic        protect_level_bit2,
  input  wire logic        protect_level_bit1,
  input  wire logic        protect_level_bit0,
  output logic             write_in_progress_ff,
  output logic             wel_clear_ff,
  output logic             arr_wr_ff,
  output logic             arr_erase_ff,
  output logic [23:0]      arr_addr_ff,
  output logic [7:0]       arr_data_ff,
  output logic [23:0]      arr_erase_mask_ff
);

  logic        cs_s1_ff, cs_s2_ff, cs_s3_ff;
  logic        sclk_s1_ff, sclk_s2_ff, sclk_s3_ff;
  logic        si_s1_ff, si_s2_ff;
  logic [7:0]  sh_ff;
  logic [2:0]  bit_ff;
  logic [9:0]  nbytes_ff;
  logic [7:0]  op_ff;
  logic [23:0] addr_ff;
  logic [255:0] mask_ff;
  logic [9:0]  rd_addr_ff;
  logic [2:0]  rd_bit_ff;
  logic [7:0]  out_sh_ff;
  npe_state_t  state_ff;
  npe_job_t    job_ff;
  logic [10:0] idx_ff;
  logic [10:0] walk_len_ff;
  logic        walk_v_ff;
  logic [9:0]  walk_idx_ff;
  logic [3:0]  tgt_ff;
  logic [1:0]  tgt_sel_ff;
  logic [23:0] base_ff;
  logic [31:0] timer_ff;

  logic        sel, cs_rise, cs_fall, sclk_rise, sclk_fall, byte_done, aligned;
  logic [7:0]  byte_val;
  logic        buf_we;
  logic [7:0]  buf_addr;
  logic [7:0]  buf_rdata;
  logic        sec_we;
  logic [9:0]  sec_addr;
  logic [7:0]  sec_wdata;
  logic [7:0]  sec_rdata;
  logic [7:0]  sec_byte;
  logic        rd_active;
  logic [1:0]  cmd_sel;
  logic [3:0]  unlocked;
  logic [2:0]  bp;
  logic [23:0] tmask;
  logic        prot;
  logic        may_start;
  logic        go_page, go_sprog, go_serase, go_erase;

  // The first stage of each synchroniser feeds only the second stage.
  always_ff @(posedge clock)
  begin
    if (reset)
    begin
      cs_s1_ff   <= 1'b1;
      cs_s2_ff   <= 1'b1;
      cs_s3_ff   <= 1'b1;
      sclk_s1_ff <= 1'b0;
      sclk_s2_ff <= 1'b0;
      sclk_s3_ff <= 1'b0;
      si_s1_ff   <= 1'b0;
      si_s2_ff   <= 1'b0;
    end
    else
    begin
      cs_s1_ff   <= cs_n;
      cs_s2_ff   <= cs_s1_ff;
      cs_s3_ff   <= cs_s2_ff;
      sclk_s1_ff <= sclk;
      sclk_s2_ff <= sclk_s1_ff;
      sclk_s3_ff <= sclk_s2_ff;
      si_s1_ff   <= si;
      si_s2_ff   <= si_s1_ff;
    end
  end

  assign sel       = ~cs_s2_ff;
  assign cs_rise   = cs_s2_ff & ~cs_s3_ff;
  assign cs_fall   = ~cs_s2_ff & cs_s3_ff;
  assign sclk_rise = sel & sclk_s2_ff & ~sclk_s3_ff;
  assign sclk_fall = sel & ~sclk_s2_ff & sclk_s3_ff;
  assign byte_done = sclk_rise & (bit_ff == 3'd7);
  assign byte_val  = {sh_ff[6:0], si_s2_ff};
  assign aligned   = (bit_ff == 3'd0);

  // Input bytes are gathered on rising serial clock edges, most significant bit first.
  always_ff @(posedge clock)
  begin
    if (reset || cs_fall)
    begin
      sh_ff     <= 8'h00;
      bit_ff    <= 3'd0;
      nbytes_ff <= 10'h000;
    end
    else if (sclk_rise)
    begin
      sh_ff  <= byte_val;
      bit_ff <= bit_ff + 3'd1;
      if (byte_done && nbytes_ff != BYTE_COUNT_MAX)
      begin
        nbytes_ff <= nbytes_ff + 10'h001;
      end
    end
  end

  always_ff @(posedge clock)
  begin
    if (reset)
    begin
      op_ff   <= 8'h00;
      addr_ff <= 24'h000000;
    end
    else if (byte_done && nbytes_ff == 10'h000)
    begin
      op_ff <= byte_val;
    end
    else if (byte_done && nbytes_ff < HDR_CMD_BYTES)
    begin
      addr_ff <= {addr_ff[15:0], byte_val};
    end
  end

  // Data bytes land at a page offset that wraps, so later bytes overwrite earlier ones.
  assign buf_we   = byte_done && nbytes_ff >= HDR_CMD_BYTES && !write_in_progress_ff &&
                    (op_ff == OP_PAGE_PROG || op_ff == OP_SEC_PROG);
  assign buf_addr = (state_ff == NPE_WALK) ? idx_ff[7:0]
                                           : addr_ff[7:0] + nbytes_ff[7:0] - HDR_CMD_BYTES[7:0];

  always_ff @(posedge clock)
  begin
    if (reset || (cs_fall && !write_in_progress_ff))
    begin
      mask_ff <= '0;
    end
    else if (buf_we)
    begin
      mask_ff[buf_addr] <= 1'b1;
    end
  end

  npe_mem #(
    .WIDTH (8),
    .DEPTH (256),
    .AW    (8)
  ) u_page_buf (
    .clock (clock),
    .we    (buf_we),
    .addr  (buf_addr),
    .wdata (byte_val),
    .rdata (buf_rdata)
  );

  // Security store: index is register select and byte; slot zero is never written.
  assign sec_we    = walk_v_ff && ((job_ff == NPE_JOB_SEC_ERASE && tgt_ff[walk_idx_ff[9:8]]) ||
                     (job_ff == NPE_JOB_SEC_PROG && mask_ff[walk_idx_ff[7:0]]));
  assign sec_wdata = (job_ff == NPE_JOB_SEC_ERASE) ? ERASED_BYTE : buf_rdata;
  assign sec_addr  = (state_ff == NPE_IDLE) ? {addr_ff[SEC_SEL_LSB+1:SEC_SEL_LSB], rd_addr_ff[7:0]}
                   : (job_ff == NPE_JOB_SEC_PROG) ? {tgt_sel_ff, walk_idx_ff[7:0]} : walk_idx_ff;

  npe_mem #(
    .WIDTH (8),
    .DEPTH (1024),
    .AW    (10)
  ) u_sec_store (
    .clock (clock),
    .we    (sec_we),
    .addr  (sec_addr),
    .wdata (sec_wdata),
    .rdata (sec_rdata)
  );

  assign sec_byte  = (addr_ff[SEC_SEL_LSB+1:SEC_SEL_LSB] == 2'd0) ? ERASED_BYTE : sec_rdata;
  // Reads are refused while busy because the store's single port belongs to the walk.
  assign rd_active = sel && op_ff == OP_SEC_READ && nbytes_ff >= HDR_READ_BYTES &&
                     !write_in_progress_ff;

  always_ff @(posedge clock)
  begin
    if (reset || cs_fall)
    begin
      rd_addr_ff <= SEC_RD_FIRST;
      rd_bit_ff  <= 3'd0;
      out_sh_ff  <= 8'h00;
      so_ff      <= 1'b0;
    end
    else if (byte_done && nbytes_ff == HDR_READ_BYTES - 10'h001)
    begin
      rd_addr_ff <= addr_ff[9:0];
    end
    else if (sclk_fall && rd_active)
    begin
      rd_bit_ff <= rd_bit_ff + 3'd1;
      if (rd_bit_ff == 3'd0)
      begin
        so_ff      <= sec_byte[7];
        out_sh_ff  <= {sec_byte[6:0], 1'b0};
        rd_addr_ff <= (rd_addr_ff == SEC_RD_LAST) ? SEC_RD_FIRST : rd_addr_ff + 10'h001;
      end
      else
      begin
        so_ff     <= out_sh_ff[7];
        out_sh_ff <= {out_sh_ff[6:0], 1'b0};
      end
    end
  end

  always_ff @(posedge clock)
  begin
    if (reset)
    begin
      so_oe_ff <= 1'b0;
    end
    else
    begin
      so_oe_ff <= rd_active;
    end
  end

  // Target checks for the command that chip select just closed.
  assign cmd_sel  = addr_ff[SEC_SEL_LSB+1:SEC_SEL_LSB];
  assign unlocked = {~per_register_otp_locks, 1'b0};
  assign bp       = {protect_level_bit2, protect_level_bit1, protect_level_bit0};

  always_comb
  begin
    tmask = PAGE_MASK;
    case (op_ff)
      OP_SECTOR_ERASE: tmask = SECTOR_MASK;
      OP_BLK32_ERASE:  tmask = BLK32_MASK;
      OP_BLK64_ERASE:  tmask = BLK64_MASK;
      default:         tmask = PAGE_MASK;
    endcase
  end

  function automatic logic prot_hit(input logic [23:0] lo, input logic [23:0] hi,
                                    input logic sec, input logic tb, input logic [2:0] lvl);
    logic [24:0] size;
    logic [24:0] plo;
    logic [24:0] phi;
    size = 25'h0000000;
    if (lvl != 3'd0)
    begin
      if (sec)
      begin
        size = lvl[2] ? SMALL_MAX_BYTES : (SECTOR_BYTES << (lvl - 3'd1));
      end
      else
      begin
        size = lvl[2] ? ARRAY_BYTES : (BLK64_BYTES << (lvl - 3'd1));
      end
    end
    plo = tb ? 25'h0000000 : ARRAY_BYTES - size;
    phi = tb ? size - 25'h0000001 : ARRAY_BYTES - 25'h0000001;
    return (size != 25'h0000000) && ({1'b0, lo} <= phi) && ({1'b0, hi} >= plo);
  endfunction

  assign prot = prot_hit(addr_ff & ~tmask, addr_ff | tmask, small_unit_protect_select,
                         top_bottom_protect_select, bp);

  // The host is trusted to hold chip select low throughout; an early rise just fails the count or bit-alignment checks.
  assign may_start = cs_rise && aligned && write_enable_latch && !write_in_progress_ff;
  assign go_page   = may_start && op_ff == OP_PAGE_PROG && nbytes_ff > HDR_CMD_BYTES && !prot;
  assign go_sprog  = may_start && op_ff == OP_SEC_PROG && nbytes_ff > HDR_CMD_BYTES && unlocked[cmd_sel];
  // Only the bare opcode erases; a frame that carries address bytes is dropped like any misframed one.
  assign go_serase = may_start && op_ff == OP_SEC_ERASE &&
                     nbytes_ff == HDR_OPCODE_BYTES && unlocked != 4'h0;
  assign go_erase  = may_start && nbytes_ff == HDR_CMD_BYTES && !prot &&
                     (op_ff == OP_SECTOR_ERASE || op_ff == OP_BLK32_ERASE || op_ff == OP_BLK64_ERASE);

  // Self-timed cycle: walk the buffer or store (array erase goes straight to the wait), then wait out the program or erase time.
  always_ff @(posedge clock)
  begin
    if (reset)
    begin
      state_ff             <= NPE_IDLE;
      job_ff               <= NPE_JOB_PAGE;
      idx_ff               <= 11'h000;
      walk_len_ff          <= WALK_PAGE_LEN;
      walk_v_ff            <= 1'b0;
      walk_idx_ff          <= 10'h000;
      tgt_ff               <= 4'h0;
      tgt_sel_ff           <= 2'd0;
      base_ff              <= 24'h000000;
      timer_ff             <= 32'h00000000;
      write_in_progress_ff <= 1'b0;
      wel_clear_ff         <= 1'b0;
    end
    else
    begin
      wel_clear_ff <= 1'b0;
      walk_v_ff    <= 1'b0;
      case (state_ff)
        NPE_IDLE:
        begin
          idx_ff     <= 11'h000;
          tgt_sel_ff <= cmd_sel;
          base_ff    <= addr_ff & ~tmask;
          if (go_page || go_sprog || go_serase || go_erase)
          begin
            write_in_progress_ff <= 1'b1;
            wel_clear_ff         <= 1'b1;
            state_ff             <= go_erase ? NPE_WAIT : NPE_WALK;
            walk_len_ff          <= go_serase ? WALK_SEC_LEN : WALK_PAGE_LEN;
            tgt_ff               <= (nbytes_ff == HDR_OPCODE_BYTES) ? unlocked : (4'h1 << cmd_sel);
            job_ff               <= go_page ? NPE_JOB_PAGE : go_sprog ? NPE_JOB_SEC_PROG :
                                    go_serase ? NPE_JOB_SEC_ERASE : NPE_JOB_ARR_ERASE;
            if (go_erase)
            begin
              timer_ff <= (op_ff == OP_SECTOR_ERASE) ? SEC_ERASE_CYCLES[31:0] : BLK_ERASE_CYCLES[31:0];
            end
            else
            begin
              timer_ff <= go_serase ? SEC_ERASE_CYCLES[31:0] : PROG_CYCLES[31:0];
            end
          end
        end
        NPE_WALK:
        begin
          walk_v_ff   <= 1'b1;
          walk_idx_ff <= idx_ff[9:0];
          idx_ff      <= idx_ff + 11'h001;
          if (idx_ff == walk_len_ff - 11'h001)
          begin
            state_ff <= NPE_WAIT;
          end
        end
        NPE_WAIT:
        begin
          if (timer_ff <= 32'h00000001)
          begin
            write_in_progress_ff <= 1'b0;
            state_ff             <= NPE_IDLE;
          end
          else
          begin
            timer_ff <= timer_ff - 32'h00000001;
          end
        end
        default:
        begin
          state_ff <= NPE_IDLE;
        end
      endcase
    end
  end

  // Main array requests; erase is one pulse carrying base address and size mask.
  always_ff @(posedge clock)
  begin
    if (reset)
    begin
      arr_wr_ff         <= 1'b0;
      arr_erase_ff      <= 1'b0;
      arr_addr_ff       <= 24'h000000;
      arr_data_ff       <= 8'h00;
      arr_erase_mask_ff <= 24'h000000;
    end
    else
    begin
      arr_wr_ff    <= walk_v_ff && job_ff == NPE_JOB_PAGE && mask_ff[walk_idx_ff[7:0]];
      arr_erase_ff <= go_erase;
      if (go_erase)
      begin
        arr_addr_ff       <= addr_ff & ~tmask;
        arr_erase_mask_ff <= tmask;
      end
      else if (walk_v_ff && job_ff == NPE_JOB_PAGE)
      begin
        arr_addr_ff <= {base_ff[23:8], walk_idx_ff[7:0]};
        arr_data_ff <= buf_rdata;
      end
    end
  end

  // Status register reads are served outside; this block never stalls the serial port while busy.

endmodule

// ===== npe_sequencer_checker.sv
// Purpose: Port assertions for the NOR command sequencer.
// Assumes: The write enable latch input is steady around the end of each frame.
// Notes:   Bound to every npe_sequencer instance below the module.
`timescale 1ns/1ps
module npe_sequencer_checker #(
  parameter int PROG_CYCLES = 50
) (
  input wire logic        clock,
  input wire logic        reset,
  input wire logic        cs_n,
  input wire logic        so_oe_ff,
  input wire logic        write_enable_latch,
  input wire logic        write_in_progress_ff,
  input wire logic        wel_clear_ff,
  input wire logic        arr_wr_ff,
  input wire logic        arr_erase_ff,
  input wire logic [23:0] arr_addr_ff,
  input wire logic [23:0] arr_erase_mask_ff
);
  logic [11:0] busy_cnt_ff;

  // Counts busy cycles so a cut-short timer shows up at the falling edge.
  always_ff @(posedge clock)
  begin
    if (reset || !write_in_progress_ff)
      busy_cnt_ff <= 12'h000;
    else
      busy_cnt_ff <= busy_cnt_ff + 12'h001;
  end

  default clocking cb @(posedge clock); endclocking
  default disable iff (reset);

  busy_start_a: assert property ($rose(write_in_progress_ff) |-> cs_n)
    else $error("busy rose while chip select low");
  busy_hold_a: assert property ($rose(write_in_progress_ff) |-> write_in_progress_ff[*8])
    else $error("busy flag dropped early");
  busy_min_a: assert property ($fell(write_in_progress_ff) |-> busy_cnt_ff >= PROG_CYCLES)
    else $error("self-timed cycle too short");
  wel_needed_a: assert property ($rose(write_in_progress_ff) |-> $past(write_enable_latch))
    else $error("cycle started without write enable");
  wel_clear_a: assert property ($rose(write_in_progress_ff) |-> wel_clear_ff)
    else $error("write enable not cleared at cycle start");
  clear_once_a: assert property (wel_clear_ff |-> $rose(write_in_progress_ff))
    else $error("write enable clear outside a cycle start");
  erase_shape_a: assert property (arr_erase_ff |-> write_in_progress_ff &&
    ((arr_addr_ff & arr_erase_mask_ff) == 24'h0) && (arr_erase_mask_ff inside {24'h000fff, 24'h007fff, 24'h00ffff}))
    else $error("bad erase base or size");
  write_busy_a: assert property (arr_wr_ff |-> write_in_progress_ff)
    else $error("array write while idle");
  read_start_a: assert property ($rose(so_oe_ff) |-> !cs_n && !write_in_progress_ff)
    else $error("read output enabled at wrong time");

  cover property ($rose(write_in_progress_ff));
  cover property ($rose(so_oe_ff));
  cover property (arr_erase_ff);
  cover property (arr_wr_ff);
endmodule

bind npe_sequencer npe_sequencer_checker #(.PROG_CYCLES(PROG_CYCLES)) u_chk (
  .clock(clock), .reset(reset), .cs_n(cs_n), .so_oe_ff(so_oe_ff), .write_enable_latch(write_enable_latch),
  .write_in_progress_ff(write_in_progress_ff), .wel_clear_ff(wel_clear_ff), .arr_wr_ff(arr_wr_ff),
  .arr_erase_ff(arr_erase_ff), .arr_addr_ff(arr_addr_ff), .arr_erase_mask_ff(arr_erase_mask_ff));

// ===== npe_host_model.sv
// Purpose: Serial host that shifts command frames in and read data out.
// Assumes: Serial clock idles low and stands still between frames.
// Notes:   Released data line toggles so a stale bit is never mistaken for data.
`timescale 1ns/1ps
module npe_host_model (
  input  wire logic clock,
  input  wire logic so_ff,
  input  wire logic so_oe_ff,
  output logic      cs_n,
  output logic      sclk,
  output logic      si
);
  logic [7:0] tx_buf [0:299];
  logic [7:0] rx_buf [0:7];

  initial
  begin
    cs_n = 1'b1;
    sclk = 1'b0;
    si = 1'b0;
  end

  task half;
    repeat (4) @(negedge clock);
  endtask

  // Data is sampled just before the rising edge, well after the device moved it.
  task tick(input logic b, output logic q);
    si = b;
    half();
    q = so_oe_ff ? so_ff : 1'bx;
    sclk = 1'b1;
    half();
    sclk = 1'b0;
  endtask

  task frame(input int nb, input int xb, input int nrx);
    int i;
    int b;
    logic q;
    cs_n = 1'b0;
    half();
    for (i = 0; i < nb; i++)
      for (b = 7; b >= 0; b--)
        tick(tx_buf[i][b], q);
    for (i = 0; i < xb; i++)
      tick(~si, q);
    for (i = 0; i < nrx; i++)
      for (b = 7; b >= 0; b--)
      begin
        tick(~si, q);
        rx_buf[i][b] = q;
      end
    half();
    cs_n = 1'b1;
    si = ~si;
    repeat (8) @(negedge clock);
  endtask
endmodule

// ===== tb_npe_sequencer.sv
// Purpose: Self-checking bench for the NOR command sequencer.
// Assumes: Shortened timers; main array writes and erases are logged at the ports.
// Notes:   Block erase timer is long enough to send a whole frame while busy.
`timescale 1ns/1ps
module tb_npe_sequencer
  import npe_pkg::*;
;
  logic        clock, reset, cs_n, sclk, si, so_ff, so_oe_ff, write_enable_latch;
  logic [2:0]  per_register_otp_locks;
  logic        small_unit_protect_select, top_bottom_protect_select;
  logic        protect_level_bit2, protect_level_bit1, protect_level_bit0;
  logic        write_in_progress_ff, wel_clear_ff, arr_wr_ff, arr_erase_ff;
  logic [23:0] arr_addr_ff, arr_erase_mask_ff, er_addr, er_mask;
  logic [7:0]  arr_data_ff;
  logic [7:0]  wr_mem [0:255];
  logic [15:0] wr_page;
  int          n_fail = 0, n_checks = 0, wr_cnt = 0, er_cnt = 0, wc_cnt = 0;

  npe_sequencer #(.PROG_CYCLES(50), .SEC_ERASE_CYCLES(60), .BLK_ERASE_CYCLES(700)) uut (
    .clock(clock), .reset(reset), .cs_n(cs_n), .sclk(sclk), .si(si), .so_ff(so_ff), .so_oe_ff(so_oe_ff),
    .write_enable_latch(write_enable_latch), .per_register_otp_locks(per_register_otp_locks),
    .small_unit_protect_select(small_unit_protect_select), .top_bottom_protect_select(top_bottom_protect_select),
    .protect_level_bit2(protect_level_bit2), .protect_level_bit1(protect_level_bit1),
    .protect_level_bit0(protect_level_bit0), .write_in_progress_ff(write_in_progress_ff),
    .wel_clear_ff(wel_clear_ff), .arr_wr_ff(arr_wr_ff), .arr_erase_ff(arr_erase_ff), .arr_addr_ff(arr_addr_ff),
    .arr_data_ff(arr_data_ff), .arr_erase_mask_ff(arr_erase_mask_ff));

  npe_host_model host (.clock(clock), .so_ff(so_ff), .so_oe_ff(so_oe_ff), .cs_n(cs_n), .sclk(sclk), .si(si));

  initial
  begin
    clock = 1'b0;
    forever #20 clock = ~clock;
  end

  always @(posedge clock)
  begin
    if (arr_wr_ff === 1'b1)
    begin
      wr_cnt++;
      wr_mem[arr_addr_ff[7:0]] <= arr_data_ff;
      wr_page <= arr_addr_ff[23:8];
    end
    if (arr_erase_ff === 1'b1)
    begin
      er_cnt++;
      er_addr <= arr_addr_ff;
      er_mask <= arr_erase_mask_ff;
    end
    if (wel_clear_ff === 1'b1)
      wc_cnt++;
  end

  task finish_test;
    $display("checks %0d failures %0d", n_checks, n_fail);
    if (n_fail == 0 && n_checks > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask

  task check(input logic [39:0] got, input logic [39:0] exp);
    n_checks++;
    if (got !== exp)
    begin
      n_fail++;
      $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // Checks whether the frame started a cycle, then waits for it to end.
  task op(input logic exp);
    int i;
    check(write_in_progress_ff, exp);
    for (i = 0; write_in_progress_ff === 1'b1; i++)
    begin
      if (i > 2000)
      begin
        n_fail++;
        finish_test();
      end
      @(negedge clock);
    end
  endtask

  task load(input logic [7:0] opc, input logic [23:0] addr);
    host.tx_buf[0] = opc;
    host.tx_buf[1] = addr[23:16];
    host.tx_buf[2] = addr[15:8];
    host.tx_buf[3] = addr[7:0];
  endtask

  task t_sec_reg;
    int c;
    c = wc_cnt;
    load(OP_SEC_ERASE, 24'h0);
    host.frame(1, 0, 0);
    op(1'b1);
    load(OP_SEC_PROG, 24'h0010fe);
    host.tx_buf[4] = 8'ha5;
    host.tx_buf[5] = 8'h5a;
    host.frame(6, 0, 0);
    op(1'b1);
    check(wc_cnt, c + 2);
    load(OP_SEC_READ, 24'h0013fe);
    host.frame(5, 0, 3);
    check(host.rx_buf[0], 8'ha5);
    check(host.rx_buf[1], 8'h5a);
    check(host.rx_buf[2], ERASED_BYTE);
  endtask

  task t_lock;
    // The bare erase clears registers two and three; the locked first one must keep its data.
    per_register_otp_locks = 3'b001;
    load(OP_SEC_ERASE, 24'h001000);
    host.frame(1, 0, 0);
    op(1'b1);
    load(OP_SEC_PROG, 24'h0010fe);
    host.tx_buf[4] = 8'h00;
    host.frame(5, 0, 0);
    op(1'b0);
    load(OP_SEC_READ, 24'h0010fe);
    host.frame(5, 0, 1);
    check(host.rx_buf[0], 8'ha5);
    per_register_otp_locks = 3'b000;
  endtask

  task t_erase;
    logic [7:0]  ops [0:2];
    logic [23:0] msk [0:2];
    int          k, n;
    ops = '{OP_SECTOR_ERASE, OP_BLK32_ERASE, OP_BLK64_ERASE};
    msk = '{24'h000fff, 24'h007fff, 24'h00ffff};
    for (k = 0; k < 3; k++)
    begin
      n = er_cnt;
      load(ops[k], 24'h034567);
      host.frame(4, 0, 0);
      op(1'b1);
      check(er_cnt, n + 1);
      check(er_addr, 24'h034567 & ~msk[k]);
      check(er_mask, msk[k]);
    end
  endtask

  task t_refuse;
    int n, w;
    n = er_cnt;
    w = wr_cnt;
    write_enable_latch = 1'b0;
    load(OP_SECTOR_ERASE, 24'h001000);
    host.frame(4, 0, 0);
    op(1'b0);
    write_enable_latch = 1'b1;
    host.frame(4, 4, 0);
    op(1'b0);
    load(OP_SEC_ERASE, 24'h0);
    host.frame(1, 4, 0);
    op(1'b0);
    load(OP_SEC_ERASE, 24'h001000);
    host.frame(4, 0, 0);
    op(1'b0);
    load(OP_PAGE_PROG, 24'h000300);
    host.tx_buf[4] = 8'h77;
    host.frame(5, 3, 0);
    op(1'b0);
    protect_level_bit0 = 1'b1;
    load(OP_SECTOR_ERASE, 24'h07f000);
    host.frame(4, 0, 0);
    op(1'b0);
    load(OP_PAGE_PROG, 24'h07ff00);
    host.frame(5, 0, 0);
    op(1'b0);
    small_unit_protect_select = 1'b1;
    top_bottom_protect_select = 1'b1;
    load(OP_SECTOR_ERASE, 24'h000000);
    host.frame(4, 0, 0);
    op(1'b0);
    small_unit_protect_select = 1'b0;
    top_bottom_protect_select = 1'b0;
    protect_level_bit0 = 1'b0;
    check(er_cnt + wr_cnt, n + w);
  endtask

  task t_page;
    int k, w;
    load(OP_PAGE_PROG, 24'h0001fe);
    host.tx_buf[4] = 8'h11;
    host.tx_buf[5] = 8'h22;
    host.tx_buf[6] = 8'h33;
    w = wr_cnt;
    host.frame(7, 0, 0);
    op(1'b1);
    check(wr_cnt, w + 3);
    check({wr_page, wr_mem[8'hfe], wr_mem[8'hff], wr_mem[8'h00]}, 40'h0001112233);
    load(OP_PAGE_PROG, 24'h000200);
    for (k = 0; k < 257; k++)
      host.tx_buf[4 + k] = (k > 255) ? 8'hc3 : k[7:0];
    w = wr_cnt;
    host.frame(261, 0, 0);
    op(1'b1);
    check(wr_cnt, w + 256);
    check({wr_mem[8'h00], wr_mem[8'h80]}, 16'hc380);
  endtask

  task t_busy;
    int n, c;
    n = er_cnt;
    c = wc_cnt;
    load(OP_BLK64_ERASE, 24'h010000);
    host.frame(4, 0, 0);
    load(OP_SECTOR_ERASE, 24'h020000);
    host.frame(4, 0, 0);
    check(write_in_progress_ff, 1'b1);
    op(1'b1);
    check(er_cnt, n + 1);
    check(wc_cnt, c + 1);
  endtask

  initial
  begin
    reset = 1'b1;
    write_enable_latch = 1'b1;
    per_register_otp_locks = 3'b000;
    small_unit_protect_select = 1'b0;
    top_bottom_protect_select = 1'b0;
    protect_level_bit2 = 1'b0;
    protect_level_bit1 = 1'b0;
    protect_level_bit0 = 1'b0;
    repeat (5) @(negedge clock);
    reset = 1'b0;
    repeat (4) @(negedge clock);
    t_sec_reg();
    t_lock();
    t_erase();
    t_refuse();
    t_page();
    t_busy();
    finish_test();
  end
endmodule
